// ===== common/vdc_defines.svh
// Purpose: timing and field constants of the video DRAM host controller
// Assumes: system clock of 100 MHz
// Notes: least times round up to whole cycles
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH

`define VDC_CLK_NS 10
`define VDC_CYC(ns) (((ns) + `VDC_CLK_NS - 1) / `VDC_CLK_NS)

// strobe phases of one RAM cycle
`define VDC_T_SETUP_NS 10
`define VDC_T_RAS_COL_NS 20
`define VDC_T_COL_CAS_NS 10
`define VDC_T_CAS_NS 60
`define VDC_T_PRE_NS 50
`define VDC_SETUP_CYC `VDC_CYC(`VDC_T_SETUP_NS)
`define VDC_RAS_COL_CYC `VDC_CYC(`VDC_T_RAS_COL_NS)
`define VDC_COL_CAS_CYC `VDC_CYC(`VDC_T_COL_CAS_NS)
`define VDC_CAS_CYC `VDC_CYC(`VDC_T_CAS_NS)
`define VDC_PRE_CYC `VDC_CYC(`VDC_T_PRE_NS)

// serial clock half period, made by a divider
`define VDC_T_SC_HALF_NS 40
`define VDC_SC_HALF_CYC `VDC_CYC(`VDC_T_SC_HALF_NS)

// idle pin levels
`define VDC_IDLE_ADDR 9'h000
`define VDC_IDLE_DATA 16'h0000

`endif

// ===== common/vdc_pkg.sv
// Purpose: types of the video DRAM host controller
// Assumes: nothing
// Notes: operation codes pick the strobe levels at the row strobe fall
package vdc_pkg;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_MASKED_READ_WRITE = 4'h2,
    OP_PLAIN_BLOCK_WRITE = 4'h3,
    OP_MASKED_BLOCK_WRITE = 4'h4,
    OP_MASKED_FLASH_WRITE = 4'h5,
    OP_MASK_REGISTER_LOAD = 4'h6,
    OP_COLOR_REGISTER_LOAD = 4'h7,
    OP_READ_TRANSFER = 4'h8,
    OP_SPLIT_READ_TRANSFER = 4'h9,
    OP_MASKED_WRITE_TRANSFER = 4'ha,
    OP_MASKED_SPLIT_WRITE_TRANSFER = 4'hb,
    OP_ROW_ONLY_REFRESH = 4'hc,
    OP_REFRESH_WITH_REGISTER_RESET = 4'hd,
    OP_REFRESH_WITH_STOP_SET = 4'he,
    OP_REFRESH_NO_RESET = 4'hf
  } vdc_op_type;

  typedef struct packed {
    vdc_op_type op;
    logic [8:0] row;
    logic [8:0] col;
    logic [15:0] data;
    logic [15:0] mask;
    logic [1:0] byte_en;
  } vdc_cmd_type;

  typedef struct packed {
    logic ras_n;
    logic col_strobe_low_byte_n;
    logic col_strobe_high_byte_n;
    logic transfer_output_enable_n;
    logic we_n;
    logic special_function_in;
    logic [8:0] mux_address_pins;
  } vdc_ram_pins_type;

  typedef struct packed {
    logic cas_n;
    logic trg_n;
    logic we_n;
    logic dsf_ras;
    logic dsf_cas;
    logic use_cas;
    logic write_data;
    logic mask_dq;
  } vdc_levels_type;

  typedef struct packed {
    logic write;
    logic hold_disabled;
    logic [15:0] data;
  } vdc_ser_req_type;

endpackage

// ===== verilog/vdc_serial.sv
// Purpose: serial port engine, makes the serial clock and moves one word per request
// Assumes: direction level from the RAM side, same clock domain
// Notes: serial clock comes from a divider, so it is no second domain
`timescale 1ns/100ps
`include "vdc_defines.svh"
module vdc_serial
  import vdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic dir_write_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire vdc_ser_req_type req_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic serial_clock_out,
  output logic serial_enable_n_out,
  output logic [15:0] serial_data_pins_out,
  output logic serial_data_pins_oe_n_out,
  input wire logic [15:0] serial_data_pins_in,
  input wire logic split_half_indicator_in,
  output logic split_half_out
);
  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_LOW = 2'b01,
    SS_HIGH = 2'b10,
    SS_SAMPLE = 2'b11
  } vdc_ser_state_type;

  vdc_ser_state_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic sc_reg, sc_next, se_n_reg, se_n_next, oe_n_reg, oe_n_next, wr_reg, wr_next;
  logic [15:0] sdo_reg, sdo_next, rsp_data_reg, rsp_data_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [16:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;

  // pins pass three flops; a change counts once stages two and three agree
  always_comb
  begin
    stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_reg <= 17'h00000;
      s2_reg <= 17'h00000;
      s3_reg <= 17'h00000;
      stable_reg <= 17'h00000;
    end
    else
    begin
      s1_reg <= {split_half_indicator_in, serial_data_pins_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sc_next = sc_reg;
    se_n_next = se_n_reg;
    oe_n_next = oe_n_reg;
    wr_next = wr_reg;
    sdo_next = sdo_reg;
    rsp_data_next = rsp_data_reg;
    rsp_valid_next = 1'b0;
    case (state_reg)
      SS_IDLE:
      begin
        if (req_valid_in)
        begin
          // data pins only driven after a write transfer turned them round
          wr_next = req_in.write & dir_write_in; // RQ11
          se_n_next = req_in.hold_disabled; // RQ10
          oe_n_next = ~(req_in.write & dir_write_in & ~req_in.hold_disabled);
          sdo_next = req_in.data;
          cnt_next = 4'(`VDC_SC_HALF_CYC - 1);
          state_next = SS_LOW;
        end
      end
      SS_LOW:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          sc_next = 1'b1; // RQ9
          cnt_next = 4'(`VDC_SC_HALF_CYC - 1);
          state_next = SS_HIGH;
        end
      end
      SS_HIGH:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          sc_next = 1'b0;
          oe_n_next = 1'b1;
          cnt_next = 4'(`VDC_SC_HALF_CYC - 1);
          state_next = SS_SAMPLE;
        end
      end
      default:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          rsp_data_next = stable_reg[15:0];
          rsp_valid_next = 1'b1;
          se_n_next = 1'b1;
          state_next = SS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SS_IDLE;
      cnt_reg <= 4'h0;
      sc_reg <= 1'b0;
      se_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      wr_reg <= 1'b0;
      sdo_reg <= `VDC_IDLE_DATA;
      rsp_data_reg <= `VDC_IDLE_DATA;
      rsp_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sc_reg <= sc_next;
      se_n_reg <= se_n_next;
      oe_n_reg <= oe_n_next;
      wr_reg <= wr_next;
      sdo_reg <= sdo_next;
      rsp_data_reg <= rsp_data_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  assign req_ready_out = (state_reg == SS_IDLE);
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out = rsp_data_reg;
  assign serial_clock_out = sc_reg;
  assign serial_enable_n_out = se_n_reg;
  assign serial_data_pins_out = sdo_reg;
  assign serial_data_pins_oe_n_out = oe_n_reg;
  assign split_half_out = stable_reg[16]; // RQ12

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_SC_HIGH_HALF: assert property ($rose(sc_reg) |-> sc_reg [*4] ##1 !sc_reg) // RQ9
    else $error("serial clock high phase has wrong length");
  AST_SDQ_DRIVEN_AT_RISE: assert property ($rose(sc_reg) && wr_reg && !se_n_reg |-> !oe_n_reg) // RQ11
    else $error("serial data not driven at serial clock rise");
endmodule // vdc_serial

// ===== verilog/vdc_ctrl.sv
// Purpose: host controller driving the strobes, address and data pins of a multiport video DRAM
// Assumes: one command at a time; strobe phase lengths set in the defines header
// Notes: pin inputs pass three flops; serial side lives in vdc_serial
// Contract
// [RQ1] nine row then nine column bits multiplexed
// [RQ2] RAM standby while row strobe high
// [RQ3] four levels at row fall pick operation
// [RQ4] transfer enable high output, low transfer
// [RQ5] write enable high plain, low masked write
// [RQ6] write enable picks transfer direction
// [RQ7] mask on data pins at row fall
// [RQ8] persistent mode uses stored mask, ignores pins
// [RQ9] serial shift on rising serial clock
// [RQ10] serial enable high blocks access, pointer advances
// [RQ11] serial enable gates output or write
// [RQ12] split half output per half, off if disabled
// [RQ13] serial pin direction follows latest transfer
// [RQ14] column-first refresh variants by write, special
// [RQ15] special high at row selects special functions
// [RQ16] special low-then-high gives block write
// [RQ17] stored mask holds until register-reset refresh
// [RQ18] stop register bounds serial operations
// [RQ19] special function latched at both strobes
// [RQ20] column strobes also enable RAM outputs
// [RQ21] registers load at later strobe/write fall
// [RQ22] block write fills eight columns from color
// [RQ23] plain row refresh without data access
`timescale 1ns/100ps
`include "vdc_defines.svh"
module vdc_ctrl
  import vdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire vdc_cmd_type cmd_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output vdc_ram_pins_type ram_pins_out,
  output logic [15:0] ram_data_pins_out,
  output logic ram_data_pins_oe_n_out,
  input wire logic [15:0] ram_data_pins_in,
  input wire logic ser_valid_in,
  output logic ser_ready_out,
  input wire vdc_ser_req_type ser_req_in,
  output logic ser_rsp_valid_out,
  output logic [15:0] ser_rsp_data_out,
  output logic serial_dir_write_out,
  output logic serial_clock_out,
  output logic serial_enable_n_out,
  output logic [15:0] serial_data_pins_out,
  output logic serial_data_pins_oe_n_out,
  input wire logic [15:0] serial_data_pins_in,
  input wire logic split_half_indicator_in,
  output logic split_half_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_RAS = 3'b010,
    ST_COL = 3'b011,
    ST_CAS = 3'b100,
    ST_PRE = 3'b101
  } vdc_state_type;

  // levels: cas_n trg_n we_n dsf_ras dsf_cas use_cas write_data mask_dq
  function automatic vdc_levels_type levels_of(input vdc_op_type op);
    case (op) // RQ3 RQ15
      OP_READ: levels_of = 8'b1110_0100; // RQ4
      OP_WRITE: levels_of = 8'b1110_0110; // RQ5
      OP_MASKED_READ_WRITE: levels_of = 8'b1100_0111; // RQ5 RQ7 RQ8
      OP_PLAIN_BLOCK_WRITE: levels_of = 8'b1110_1110; // RQ16 RQ22
      OP_MASKED_BLOCK_WRITE: levels_of = 8'b1100_1111; // RQ16 RQ17
      OP_MASKED_FLASH_WRITE: levels_of = 8'b1101_0001; // RQ17
      OP_MASK_REGISTER_LOAD: levels_of = 8'b1111_0110; // RQ21
      OP_COLOR_REGISTER_LOAD: levels_of = 8'b1111_1110; // RQ21
      OP_READ_TRANSFER: levels_of = 8'b1010_0100; // RQ6
      OP_SPLIT_READ_TRANSFER: levels_of = 8'b1011_0100;
      OP_MASKED_WRITE_TRANSFER: levels_of = 8'b1000_0101; // RQ6
      OP_MASKED_SPLIT_WRITE_TRANSFER: levels_of = 8'b1001_0101;
      OP_ROW_ONLY_REFRESH: levels_of = 8'b1110_0000; // RQ23
      OP_REFRESH_WITH_REGISTER_RESET: levels_of = 8'b0110_0000; // RQ14 RQ17
      OP_REFRESH_WITH_STOP_SET: levels_of = 8'b0101_0000; // RQ14 RQ18
      default: levels_of = 8'b0111_0000; // RQ14
    endcase
  endfunction

  vdc_state_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  vdc_cmd_type cmd_reg, cmd_next;
  vdc_ram_pins_type pins_reg, pins_next;
  logic [15:0] dq_reg, dq_next, rsp_data_reg, rsp_data_next;
  logic dq_oe_n_reg, dq_oe_n_next, rsp_valid_reg, rsp_valid_next, dir_write_reg, dir_write_next;
  logic [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_stable_reg, dq_stable_next;
  vdc_levels_type lvl_in, lvl;

  assign lvl_in = levels_of(cmd_in.op);
  assign lvl = levels_of(cmd_reg.op);

  // read data passes three flops; a change counts once stages two and three agree
  always_comb
  begin
    dq_stable_next = (dq_s2_reg == dq_s3_reg) ? dq_s3_reg : dq_stable_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dq_s1_reg <= `VDC_IDLE_DATA;
      dq_s2_reg <= `VDC_IDLE_DATA;
      dq_s3_reg <= `VDC_IDLE_DATA;
      dq_stable_reg <= `VDC_IDLE_DATA;
    end
    else
    begin
      dq_s1_reg <= ram_data_pins_in;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
      dq_stable_reg <= dq_stable_next;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    pins_next = pins_reg;
    dq_next = dq_reg;
    dq_oe_n_next = dq_oe_n_reg;
    rsp_data_next = rsp_data_reg;
    rsp_valid_next = 1'b0;
    dir_write_next = dir_write_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (cmd_valid_in)
        begin
          cmd_next = cmd_in;
          pins_next.mux_address_pins = cmd_in.row; // RQ1
          pins_next.col_strobe_low_byte_n = lvl_in.cas_n; // RQ14
          pins_next.col_strobe_high_byte_n = lvl_in.cas_n;
          pins_next.transfer_output_enable_n = lvl_in.trg_n; // RQ4
          pins_next.we_n = lvl_in.we_n; // RQ5 RQ6
          pins_next.special_function_in = lvl_in.dsf_ras; // RQ19
          // new mask presented for the row fall; persistent mode simply ignores it
          dq_next = cmd_in.mask; // RQ7
          dq_oe_n_next = ~lvl_in.mask_dq;
          cnt_next = 4'(`VDC_SETUP_CYC - 1);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          pins_next.ras_n = 1'b0; // RQ2
          cnt_next = 4'(`VDC_RAS_COL_CYC - 1);
          state_next = ST_RAS;
        end
      end
      ST_RAS:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          dq_oe_n_next = 1'b1;
          if (lvl.use_cas)
          begin
            pins_next.mux_address_pins = cmd_reg.col; // RQ1
            pins_next.special_function_in = lvl.dsf_cas; // RQ16 RQ19
            pins_next.transfer_output_enable_n = 1'b1;
            pins_next.we_n = lvl.write_data ? 1'b0 : lvl.we_n;
            dq_next = cmd_reg.data;
            dq_oe_n_next = ~lvl.write_data;
            cnt_next = 4'(`VDC_COL_CAS_CYC - 1);
            state_next = ST_COL;
          end
          else
          begin
            // flash write and refreshes skip the column address phase
            cnt_next = 4'(`VDC_CAS_CYC - 1);
            state_next = ST_CAS;
          end
        end
      end
      ST_COL:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          // early write: write strobe already low, so the load happens at this fall
          pins_next.col_strobe_low_byte_n = ~cmd_reg.byte_en[0]; // RQ20 RQ21
          pins_next.col_strobe_high_byte_n = ~cmd_reg.byte_en[1];
          cnt_next = 4'(`VDC_CAS_CYC - 1);
          state_next = ST_CAS;
        end
      end
      ST_CAS:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          rsp_data_next = dq_stable_reg;
          rsp_valid_next = 1'b1;
          pins_next = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, `VDC_IDLE_ADDR};
          dq_oe_n_next = 1'b1;
          if (cmd_reg.op == OP_READ_TRANSFER || cmd_reg.op == OP_SPLIT_READ_TRANSFER)
            dir_write_next = 1'b0; // RQ13
          else if (cmd_reg.op == OP_MASKED_WRITE_TRANSFER || cmd_reg.op == OP_MASKED_SPLIT_WRITE_TRANSFER)
            dir_write_next = 1'b1; // RQ13
          cnt_next = 4'(`VDC_PRE_CYC - 1);
          state_next = ST_PRE;
        end
      end
      default:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
          state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      cmd_reg <= '0;
      pins_reg <= {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, `VDC_IDLE_ADDR};
      dq_reg <= `VDC_IDLE_DATA;
      dq_oe_n_reg <= 1'b1;
      rsp_data_reg <= `VDC_IDLE_DATA;
      rsp_valid_reg <= 1'b0;
      dir_write_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      pins_reg <= pins_next;
      dq_reg <= dq_next;
      dq_oe_n_reg <= dq_oe_n_next;
      rsp_data_reg <= rsp_data_next;
      rsp_valid_reg <= rsp_valid_next;
      dir_write_reg <= dir_write_next;
    end
  end

  assign cmd_ready_out = (state_reg == ST_IDLE);
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out = rsp_data_reg;
  assign ram_pins_out = pins_reg;
  assign ram_data_pins_out = dq_reg;
  assign ram_data_pins_oe_n_out = dq_oe_n_reg;
  assign serial_dir_write_out = dir_write_reg;

  vdc_serial u_serial (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .dir_write_in(dir_write_reg),
    .req_valid_in(ser_valid_in),
    .req_ready_out(ser_ready_out),
    .req_in(ser_req_in),
    .rsp_valid_out(ser_rsp_valid_out),
    .rsp_data_out(ser_rsp_data_out),
    .serial_clock_out(serial_clock_out),
    .serial_enable_n_out(serial_enable_n_out),
    .serial_data_pins_out(serial_data_pins_out),
    .serial_data_pins_oe_n_out(serial_data_pins_oe_n_out),
    .serial_data_pins_in(serial_data_pins_in),
    .split_half_indicator_in(split_half_indicator_in),
    .split_half_out(split_half_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_ras_fall;
    $fell(pins_reg.ras_n);
  endsequence
  sequence seq_cas_fall;
    // column-first refresh drops the column strobes with row high; not a column latch
    ($fell(pins_reg.col_strobe_low_byte_n) || $fell(pins_reg.col_strobe_high_byte_n)) && !pins_reg.ras_n;
  endsequence

  AST_ROW_ADDR_AT_RAS: assert property (seq_ras_fall |-> pins_reg.mux_address_pins == cmd_reg.row) // RQ1
    else $error("row address not on pins at row strobe fall");
  AST_COL_ADDR_AT_CAS: assert property (seq_cas_fall |-> pins_reg.mux_address_pins == cmd_reg.col) // RQ1
    else $error("column address not on pins at column strobe fall");
  AST_IDLE_STANDBY: assert property (state_reg == ST_IDLE |-> pins_reg.ras_n && pins_reg.we_n) // RQ2
    else $error("row strobe low while idle");
  AST_MODE_LEVELS: assert property (seq_ras_fall |-> pins_reg.transfer_output_enable_n == lvl.trg_n
      && pins_reg.we_n == lvl.we_n && pins_reg.special_function_in == lvl.dsf_ras) // RQ3
    else $error("mode levels wrong at row strobe fall");
  AST_DSF_AT_CAS: assert property (seq_cas_fall |-> pins_reg.special_function_in == lvl.dsf_cas) // RQ19
    else $error("special function level wrong at column strobe fall");
  AST_MASK_ON_DQ: assert property (seq_ras_fall and lvl.mask_dq |-> !dq_oe_n_reg && dq_reg == cmd_reg.mask) // RQ7
    else $error("write mask not driven at row strobe fall");
  AST_CBR_ORDER: assert property (seq_ras_fall and !lvl.cas_n |-> $past(pins_reg.col_strobe_low_byte_n) == 1'b0) // RQ14
    else $error("column strobe not low before row strobe fall");
  AST_WRITE_STROBE: assert property (seq_cas_fall and lvl.write_data |-> !pins_reg.we_n && !dq_oe_n_reg) // RQ5
    else $error("write data not driven at column strobe fall");
  AST_TRG_RISE: assert property (seq_ras_fall and !lvl.trg_n |-> ##[1:8] $rose(pins_reg.transfer_output_enable_n)) // RQ4
    else $error("transfer enable did not rise after transfer start");
  AST_ROW_REFRESH_QUIET: assert property (seq_ras_fall and cmd_reg.op == OP_ROW_ONLY_REFRESH
      |-> (pins_reg.col_strobe_low_byte_n && dq_oe_n_reg) [*6]) // RQ23
    else $error("row-only refresh touched the data path");
endmodule // vdc_ctrl

// ===== tb/vdc_dram_model.sv
// Purpose: behavioural multiport video DRAM seen from its pins
// Assumes: both column strobes move together
// Notes: block and flash write data effects not modelled
`timescale 1ns/100ps
module vdc_dram_model
  import vdc_pkg::*;
(
  input wire vdc_ram_pins_type pins_in,
  input wire logic [15:0] dq_in,
  input wire logic serial_clock_in,
  input wire logic serial_enable_n_in,
  input wire logic [15:0] sdq_in,
  output logic [15:0] dq_out,
  output logic [15:0] sdq_out,
  output logic split_half_indicator_out
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] serial_register [512];
  logic [3:0] lv_reg = 4'h0;
  logic [8:0] row_reg, col_reg, stop_reg, ptr_reg = 9'h000;
  logic [15:0] pin_mask_reg, mask_reg, color_reg, m, rd_reg = 16'h0000, so_reg = 16'h0000, last_wr_reg = 16'h0000;
  logic dsf_cas_reg, persist_reg = 1'b0, dir_wr_reg = 1'b0;

  always @(negedge pins_in.ras_n)
  begin
    lv_reg = {pins_in.col_strobe_low_byte_n, pins_in.transfer_output_enable_n, pins_in.we_n,
      pins_in.special_function_in};
    row_reg = pins_in.mux_address_pins;
    pin_mask_reg = dq_in;
    if (!lv_reg[3] && lv_reg[1] && !lv_reg[0])
      persist_reg = 1'b0;
    if (!lv_reg[3] && !lv_reg[1] && lv_reg[0])
      stop_reg = pins_in.mux_address_pins;
    if (lv_reg[3] && !lv_reg[2])
      dir_wr_reg = !lv_reg[1];
  end

  always @(negedge pins_in.col_strobe_low_byte_n)
  begin
    if (!pins_in.ras_n && lv_reg[3])
    begin
      col_reg = pins_in.mux_address_pins;
      dsf_cas_reg = pins_in.special_function_in;
      m = lv_reg[1] ? 16'hffff : persist_reg ? mask_reg : pin_mask_reg;
      rd_reg = mem.exists({row_reg, col_reg}) ? mem[{row_reg, col_reg}] : 16'h0000;
      if (!lv_reg[2])
      begin
        ptr_reg = col_reg;
        if (lv_reg[1])
          foreach (serial_register[i])
            serial_register[i] = mem.exists({row_reg, i[8:0]}) ? mem[{row_reg, i[8:0]}] : 16'h0000;
      end
      else if (lv_reg[1] && lv_reg[0])
      begin
        // register loads take the pins at the strobe fall
        if (dsf_cas_reg)
          color_reg = dq_in;
        else
          {persist_reg, mask_reg} = {1'b1, dq_in};
      end
      else if (!lv_reg[0] && !dsf_cas_reg && !pins_in.we_n)
        mem[{row_reg, col_reg}] = (rd_reg & ~m) | (dq_in & m);
    end
  end

  always @(posedge serial_clock_in)
  begin
    if (!serial_enable_n_in && dir_wr_reg)
      {serial_register[ptr_reg], last_wr_reg} = {sdq_in, sdq_in};
    else if (!serial_enable_n_in)
      so_reg = serial_register[ptr_reg];
    ptr_reg = ptr_reg + 9'h001;
  end

  // released lines show the inverse so stale values never pass
  assign dq_out = (!pins_in.ras_n && !pins_in.col_strobe_low_byte_n && lv_reg[2] && pins_in.we_n) ?
    rd_reg : ~rd_reg;
  assign sdq_out = (serial_enable_n_in || dir_wr_reg) ? ~so_reg : so_reg;
  assign split_half_indicator_out = serial_enable_n_in ? ~ptr_reg[8] : ptr_reg[8];
endmodule // vdc_dram_model

// ===== tb/vdc_ctrl_tb.sv
// Purpose: self-checking bench of the video DRAM host controller
// Assumes: model answers at once
// Notes: rows hold op, ras-fall levels and care bits
`timescale 1ns/100ps
module vdc_ctrl_tb
  import vdc_pkg::*;
;
  logic clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, ser_valid_in = 1'b0;
  vdc_cmd_type cmd_in = '0;
  vdc_ser_req_type ser_req_in = '0;
  vdc_ram_pins_type ram_pins_out;
  logic [15:0] ram_data_pins_out, rsp_data_out, ser_rsp_data_out, serial_data_pins_out, m_dq, m_sdq, rsp_q, q;
  logic cmd_ready_out, rsp_valid_out, ram_data_pins_oe_n_out, ser_ready_out, ser_rsp_valid_out;
  logic serial_dir_write_out, serial_clock_out, serial_enable_n_out, serial_data_pins_oe_n_out, split_half_indicator, split_half_out;
  wire [15:0] dq = ram_data_pins_oe_n_out ? m_dq : ram_data_pins_out;
  wire [15:0] sdq = serial_data_pins_oe_n_out ? m_sdq : serial_data_pins_out;
  int bad_count = 0, comparisons = 0, lat;
  logic [8:0] p;
  logic [11:0] rows [16] = '{12'h0ef, 12'h1ef, 12'h2cf, 12'h3ef, 12'h4cf, 12'h5df, 12'h6ff, 12'h7ff,
    12'h8af, 12'h9bf, 12'ha8f, 12'hb9f, 12'hccd, 12'hd2b, 12'he1b, 12'hf3b};

  always #5 clk_in = ~clk_in;

  vdc_ctrl u_vdc_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_in(cmd_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .ram_pins_out(ram_pins_out), .ram_data_pins_out(ram_data_pins_out), .ram_data_pins_oe_n_out(ram_data_pins_oe_n_out),
    .ram_data_pins_in(dq), .ser_valid_in(ser_valid_in), .ser_ready_out(ser_ready_out), .ser_req_in(ser_req_in),
    .ser_rsp_valid_out(ser_rsp_valid_out), .ser_rsp_data_out(ser_rsp_data_out),
    .serial_dir_write_out(serial_dir_write_out), .serial_clock_out(serial_clock_out),
    .serial_enable_n_out(serial_enable_n_out), .serial_data_pins_out(serial_data_pins_out),
    .serial_data_pins_oe_n_out(serial_data_pins_oe_n_out), .serial_data_pins_in(sdq),
    .split_half_indicator_in(split_half_indicator), .split_half_out(split_half_out));

  vdc_dram_model u_vdc_dram_model (.pins_in(ram_pins_out), .dq_in(dq), .serial_clock_in(serial_clock_out),
    .serial_enable_n_in(serial_enable_n_out), .sdq_in(sdq), .dq_out(m_dq), .sdq_out(m_sdq),
    .split_half_indicator_out(split_half_indicator));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask

  task automatic run_cmd(input vdc_op_type op, input logic [8:0] row, col, input logic [15:0] data, mask);
    int n;
    wait_hi(cmd_ready_out, n);
    cmd_in = '{op, row, col, data, mask, 2'b11};
    cmd_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
    wait_hi(rsp_valid_out, lat);
    rsp_q = rsp_data_out;
  endtask

  task automatic op5(input vdc_op_type op, input logic [15:0] data, mask);
    run_cmd(op, 9'h005, 9'h009, data, mask);
  endtask

  task automatic run_ser(input logic wr, hold, input logic [15:0] d);
    int n;
    wait_hi(ser_ready_out, n);
    ser_req_in = '{wr, hold, d};
    ser_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    ser_valid_in = 1'b0;
    wait_hi(ser_rsp_valid_out, n);
    check("ser_latency", n, 12);
    q = ser_rsp_data_out;
  endtask

  task test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    check("ras_idle", ram_pins_out.ras_n, 1);
    check("se_idle", serial_enable_n_out, 1);
    for (int r = 0; r < 16; r++)
    begin
      run_cmd(vdc_op_type'(rows[r][11:8]), 9'(r * 3 + 1), 9'(r + 16), 16'h1234, 16'h00ff);
      check("mode", u_vdc_dram_model.lv_reg & rows[r][3:0], rows[r][7:4] & rows[r][3:0]);
      if (r != 5)
        check("latency", lat, r > 11 ? 9 : 10);
      if (r < 13)
        check("row", u_vdc_dram_model.row_reg, r * 3 + 1);
      if (r < 3)
        check("col", u_vdc_dram_model.col_reg, r + 16);
      if (r < 8 && r != 5)
        check("dsf_cas", u_vdc_dram_model.dsf_cas_reg, r == 3 || r == 4 || r == 7);
      if (r > 7 && r < 12)
        check("dir", serial_dir_write_out, r > 9);
    end
    op5(OP_WRITE, 16'ha5a5, 16'h0000);
    op5(OP_READ, 16'h0000, 16'h0000);
    check("rd_plain", rsp_q, 16'ha5a5);
    op5(OP_MASKED_READ_WRITE, 16'h5a5a, 16'h00ff);
    op5(OP_READ, 16'h0000, 16'h0000);
    check("rd_new_mask", rsp_q, 16'ha55a);
    op5(OP_MASK_REGISTER_LOAD, 16'h0f0f, 16'h0000);
    op5(OP_MASKED_READ_WRITE, 16'hffff, 16'hffff);
    op5(OP_READ, 16'h0000, 16'h0000);
    check("rd_stored_mask", rsp_q, 16'haf5f);
    op5(OP_REFRESH_WITH_REGISTER_RESET, 16'h0000, 16'h0000);
    op5(OP_MASKED_READ_WRITE, 16'h0000, 16'hf000);
    op5(OP_READ, 16'h0000, 16'h0000);
    check("rd_mask_cleared", rsp_q, 16'h0f5f);
    op5(OP_READ_TRANSFER, 16'h0000, 16'h0000);
    check("dir_rt", serial_dir_write_out, 0);
    run_ser(1'b0, 1'b0, 16'h0000);
    check("ser_rd", q, 16'h0f5f);
    check("split_half", split_half_out, 0);
    op5(OP_MASKED_WRITE_TRANSFER, 16'h0000, 16'hffff);
    check("dir_wt", serial_dir_write_out, 1);
    p = u_vdc_dram_model.ptr_reg;
    run_ser(1'b1, 1'b0, 16'h1234);
    check("ser_wr", u_vdc_dram_model.last_wr_reg, 16'h1234);
    run_ser(1'b1, 1'b1, 16'h5678);
    check("ser_blocked", u_vdc_dram_model.last_wr_reg, 16'h1234);
    check("ptr_adv", u_vdc_dram_model.ptr_reg, p + 9'h002);
    // reset lands before the column strobe, so the write never happens
    cmd_in = '{OP_WRITE, 9'h005, 9'h009, 16'hdead, 16'h0000, 2'b11};
    cmd_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rst_n_in = 1'b0;
    #1;
    check("ras_reset", ram_pins_out.ras_n, 1);
    @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    op5(OP_READ, 16'h0000, 16'h0000);
    check("rd_after_reset", rsp_q, 16'h0f5f);
    test_done();
  end
endmodule // vdc_ctrl_tb
